// [pwseq_top.sv]
// turn-on sequencing, power-good and turn-on timeout response
`timescale 1ns/1ps
`default_nettype none
module pwseq_top #(
  parameter int MS_CYCLES_P = pwseq_pkg::MS_CYCLES
) (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic enable_pin_in,
  input wire logic [15:0] vout_in,
  input wire logic [15:0] uv_limit_in,
  input wire logic pg_pin_enable_in,
  input wire logic clear_faults_in,
  input wire logic clear_fault_bit_in,
  input wire logic cmd_write_in,
  input wire logic cmd_read_in,
  input wire logic [7:0] cmd_code_in,
  input wire logic [15:0] cmd_data_in,
  output logic [15:0] read_data_out,
  output logic read_valid_out,
  output logic output_enable_out,
  output logic ramp_active_out,
  output logic power_good_out,
  output logic power_good_status_out,
  output logic timeout_fault_out,
  output logic [2:0] attempt_count_out
);
  import pwseq_pkg::*;

  localparam int TICK_W = $clog2(MS_CYCLES_P + 1);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(MS_CYCLES_P - 1);

  // ***************************************************
  // linear format to milliseconds
  // ***************************************************
  function automatic logic [MS_W-1:0] lin_to_ms(input logic [15:0] v);
    logic [4:0] e;
    logic [10:0] m;
    logic [47:0] w;
    e = v[LIN_EXP_MSB:LIN_EXP_LSB];
    m = v[LIN_MANT_MSB:0];
    w = {37'h0, m};
    if (m[LIN_MANT_MSB])
      lin_to_ms = '0;
    else if (e[4])
      lin_to_ms = MS_W'(w >> ((~e) + 5'h1));
    else
    begin
      w = w << e;
      lin_to_ms = (|w[47:MS_W]) ? {MS_W{1'b1}} : w[MS_W-1:0];
    end
  endfunction

  // ***************************************************
  // command registers
  // ***************************************************
  logic [15:0] power_good_assert_threshold;
  logic [15:0] power_good_negate_threshold;
  logic [15:0] turn_on_delay;
  logic [15:0] turn_on_rise_time;
  logic [15:0] turn_on_timeout_limit;
  logic [7:0] turn_on_timeout_response;
  logic [15:0] fault_time_unit;
  logic [2:0] wr_retry;

  assign wr_retry = cmd_data_in[RETRY_MSB:RETRY_LSB];

  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      power_good_assert_threshold <= RST_WORD;
      power_good_negate_threshold <= RST_WORD;
      turn_on_delay <= RST_WORD;
      turn_on_rise_time <= RST_WORD;
      turn_on_timeout_limit <= RST_WORD;
      turn_on_timeout_response <= RST_RESP;
      fault_time_unit <= RST_FAULT_UNIT;
    end
    else if (cmd_write_in)
    begin
      case (cmd_code_in)
        CMD_PG_ASSERT: power_good_assert_threshold <= cmd_data_in;
        CMD_PG_NEGATE: power_good_negate_threshold <= cmd_data_in;
        CMD_ON_DELAY: turn_on_delay <= cmd_data_in;
        CMD_ON_RISE: turn_on_rise_time <= cmd_data_in;
        CMD_TON_LIMIT: turn_on_timeout_limit <= cmd_data_in;
        CMD_TON_RESP:
          // unsupported retry counts leave the old setting
          if (wr_retry <= RETRY_MAX_COUNTED ||
              wr_retry == RETRY_FOREVER)
            turn_on_timeout_response <= cmd_data_in[7:0];
        CMD_FAULT_UNIT: fault_time_unit <= cmd_data_in;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      read_data_out <= RST_WORD;
      read_valid_out <= 1'b0;
    end
    else
    begin
      read_valid_out <= cmd_read_in;
      if (cmd_read_in)
        case (cmd_code_in)
          CMD_PG_ASSERT: read_data_out <= power_good_assert_threshold;
          CMD_PG_NEGATE: read_data_out <= power_good_negate_threshold;
          CMD_ON_DELAY: read_data_out <= turn_on_delay;
          CMD_ON_RISE: read_data_out <= turn_on_rise_time;
          CMD_TON_LIMIT: read_data_out <= turn_on_timeout_limit;
          CMD_TON_RESP: read_data_out <= {8'h00, turn_on_timeout_response};
          CMD_FAULT_UNIT: read_data_out <= fault_time_unit;
          default: read_data_out <= RST_WORD;
        endcase
    end
  end

  // ***************************************************
  // enable pin synchroniser and millisecond tick
  // ***************************************************
  logic [2:0] en_sync;
  logic enable;
  logic [TICK_W-1:0] tick_count;
  logic ms_tick;

  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      en_sync <= 3'h0;
      enable <= 1'b0;
    end
    else
    begin
      en_sync <= {en_sync[1:0], enable_pin_in};
      if (en_sync[1] == en_sync[2])
        enable <= en_sync[2];
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      tick_count <= '0;
      ms_tick <= 1'b0;
    end
    else
    begin
      ms_tick <= (tick_count == TICK_LAST);
      tick_count <= (tick_count == TICK_LAST) ? '0 : tick_count + TICK_W'(1);
    end
  end

  // ***************************************************
  // timers
  // ***************************************************
  pwseq_state_t state;
  pwseq_state_t next_state;
  logic [MS_W-1:0] phase_ms;
  logic [MS_W-1:0] attempt_ms;
  logic phase_clear;
  logic attempt_start;

  assign phase_clear = (next_state != state);
  assign attempt_start = (next_state == ST_DELAY) && (state != ST_DELAY);

  pwseq_ms_timer #(.WIDTH(MS_W)) phase_timer (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .clear_in(phase_clear),
    .tick_in(ms_tick),
    .elapsed_out(phase_ms)
  );

  pwseq_ms_timer #(.WIDTH(MS_W)) attempt_timer (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .clear_in(attempt_start),
    .tick_in(ms_tick),
    .elapsed_out(attempt_ms)
  );

  // ***************************************************
  // derived settings
  // ***************************************************
  logic [MS_W-1:0] delay_ms;
  logic [MS_W-1:0] rise_ms;
  logic [MS_W-1:0] limit_ms;
  logic [MS_W-1:0] units_ms;
  logic [1:0] resp_code;
  logic [2:0] retry_set;
  logic [2:0] unit_exp;
  logic clear_req;

  assign delay_ms = lin_to_ms(turn_on_delay);
  assign rise_ms = lin_to_ms(turn_on_rise_time);
  assign limit_ms = lin_to_ms(turn_on_timeout_limit);
  assign resp_code = turn_on_timeout_response[RESP_CODE_MSB:RESP_CODE_LSB];
  assign retry_set = turn_on_timeout_response[RETRY_MSB:RETRY_LSB];
  assign unit_exp = turn_on_timeout_response[UNITS_MSB:UNITS_LSB];
  assign units_ms = MS_W'({8'h00, fault_time_unit} << unit_exp);
  assign clear_req = clear_faults_in || clear_fault_bit_in;

  // ***************************************************
  // timeout detection
  // ***************************************************
  logic reached;
  logic fired;
  logic starting;
  logic timeout_hit;
  logic may_retry;

  assign starting = (state == ST_DELAY) || (state == ST_RISE) ||
                    (state == ST_RUN);
  assign timeout_hit = starting && !reached && !fired &&
                       (limit_ms != '0) && (attempt_ms >= limit_ms);
  assign may_retry = (retry_set == RETRY_FOREVER) ||
                     ((retry_set != RETRY_NONE) &&
                      (attempt_count_out < retry_set));

  always_ff @(posedge clock_in)
  begin
    if (reset_in || attempt_start)
    begin
      reached <= 1'b0;
      fired <= 1'b0;
    end
    else
    begin
      if ((state == ST_RISE || state == ST_RUN || state == ST_RESP_WAIT) &&
          vout_in >= uv_limit_in)
        reached <= 1'b1;
      if (timeout_hit)
        fired <= 1'b1;
    end
  end

  // ***************************************************
  // sequencing state machine
  // ***************************************************
  always_comb
  begin
    next_state = state;
    case (state)
      ST_IDLE:
        if (enable)
          next_state = ST_DELAY;
      ST_DELAY:
        if (phase_ms >= delay_ms)
          next_state = ST_RISE;
      ST_RISE:
        if (phase_ms >= rise_ms)
          next_state = ST_RUN;
      ST_RUN: next_state = ST_RUN;
      ST_RESP_WAIT:
        if (reached)
          next_state = ST_RUN;
        else if (phase_ms >= units_ms)
          next_state = may_retry ? ST_RETRY_WAIT : ST_LATCHED;
      ST_RETRY_WAIT:
        if (phase_ms >= units_ms)
          next_state = ST_DELAY;
      ST_LATCHED:
        if (clear_req)
          next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
    if (timeout_hit)
    begin
      case (resp_code)
        RESP_IGNORE: next_state = state;
        RESP_DELAYED: next_state = ST_RESP_WAIT;
        RESP_DISABLE_RETRY:
          next_state = may_retry ? ST_RETRY_WAIT : ST_LATCHED;
        RESP_LATCH_OFF: next_state = ST_LATCHED;
        default: next_state = ST_LATCHED;
      endcase
    end
    if (!enable)
      next_state = ST_IDLE;
  end

  always_ff @(posedge clock_in)
  begin
    if (reset_in)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

  always_ff @(posedge clock_in)
  begin
    if (reset_in)
      attempt_count_out <= 3'h0;
    else if (next_state == ST_IDLE || reached || clear_req)
      attempt_count_out <= 3'h0;
    else if (state == ST_RETRY_WAIT && next_state == ST_DELAY &&
             retry_set != RETRY_FOREVER)
      attempt_count_out <= attempt_count_out + 3'h1;
  end

  // ***************************************************
  // outputs
  // ***************************************************
  logic pg_state;
  logic next_pg;

  always_comb
  begin
    next_pg = pg_state;
    if (next_state != ST_RUN && next_state != ST_RESP_WAIT)
      next_pg = 1'b0;
    else if (vout_in < power_good_negate_threshold)
      next_pg = 1'b0;
    else if (vout_in >= power_good_assert_threshold)
      next_pg = 1'b1;
  end

  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      pg_state <= 1'b0;
      power_good_out <= 1'b0;
      power_good_status_out <= 1'b1;
    end
    else
    begin
      pg_state <= next_pg;
      power_good_out <= next_pg && pg_pin_enable_in;
      power_good_status_out <= !next_pg;
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      output_enable_out <= 1'b0;
      ramp_active_out <= 1'b0;
    end
    else
    begin
      output_enable_out <= (next_state == ST_RISE) ||
                           (next_state == ST_RUN) ||
                           (next_state == ST_RESP_WAIT);
      ramp_active_out <= (next_state == ST_RISE);
    end
  end

  // fault flag: a new timeout wins over a clear in the same cycle
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
      timeout_fault_out <= 1'b0;
    else if (timeout_hit)
      timeout_fault_out <= 1'b1;
    else if (clear_req || (state == ST_IDLE && !enable))
      timeout_fault_out <= 1'b0;
  end

endmodule
`default_nettype wire

// [pwseq_pkg.sv]
// constants, register map and types for the power-on sequencer
package pwseq_pkg;

  // ***************************************************
  // command codes
  // ***************************************************
  localparam logic [7:0] CMD_PG_ASSERT = 8'h5E;
  localparam logic [7:0] CMD_PG_NEGATE = 8'h5F;
  localparam logic [7:0] CMD_ON_DELAY = 8'h60;
  localparam logic [7:0] CMD_ON_RISE = 8'h61;
  localparam logic [7:0] CMD_TON_LIMIT = 8'h62;
  localparam logic [7:0] CMD_TON_RESP = 8'h63;
  localparam logic [7:0] CMD_FAULT_UNIT = 8'hD2;

  // ***************************************************
  // reset values
  // ***************************************************
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [7:0] RST_RESP = 8'h00;
  localparam logic [15:0] RST_FAULT_UNIT = 16'h0001;

  // ***************************************************
  // field layouts
  // ***************************************************
  localparam int LIN_EXP_MSB = 15;
  localparam int LIN_EXP_LSB = 11;
  localparam int LIN_MANT_MSB = 10;
  localparam int RESP_CODE_MSB = 7;
  localparam int RESP_CODE_LSB = 6;
  localparam int RETRY_MSB = 5;
  localparam int RETRY_LSB = 3;
  localparam int UNITS_MSB = 2;
  localparam int UNITS_LSB = 0;
  localparam int MS_W = 24;

  // ***************************************************
  // response and retry encodings
  // ***************************************************
  localparam logic [1:0] RESP_IGNORE = 2'h0;
  localparam logic [1:0] RESP_DELAYED = 2'h1;
  localparam logic [1:0] RESP_DISABLE_RETRY = 2'h2;
  localparam logic [1:0] RESP_LATCH_OFF = 2'h3;
  localparam logic [2:0] RETRY_NONE = 3'h0;
  localparam logic [2:0] RETRY_MAX_COUNTED = 3'h3;
  localparam logic [2:0] RETRY_FOREVER = 3'h7;

  // ***************************************************
  // timing
  // ***************************************************
  localparam int CLOCK_HZ = 10000000;
  localparam int MS_PER_S = 1000;
  localparam int MS_CYCLES = CLOCK_HZ / MS_PER_S;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DELAY,
    ST_RISE,
    ST_RUN,
    ST_RESP_WAIT,
    ST_RETRY_WAIT,
    ST_LATCHED
  } pwseq_state_t;

endpackage

// [pwseq_ms_timer.sv]
// millisecond elapsed-time counter, restarted by a clear pulse
`timescale 1ns/1ps
`default_nettype none
module pwseq_ms_timer #(
  parameter int WIDTH = 24
) (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic clear_in,
  input wire logic tick_in,
  output logic [WIDTH-1:0] elapsed_out
);

  // saturates so a long wait never wraps back to small values
  always_ff @(posedge clock_in)
  begin
    if (reset_in || clear_in)
    begin
      elapsed_out <= '0;
    end
    else if (tick_in && !(&elapsed_out))
    begin
      elapsed_out <= elapsed_out + WIDTH'(1);
    end
  end

endmodule
`default_nettype wire

// [pwseq_asserts.sv]
// port assertions for the power-on sequencer
`timescale 1ns/1ps
`default_nettype none
module pwseq_asserts #(
  parameter int MS_CYCLES_P = 10
) (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic enable_pin_in,
  input wire logic [15:0] vout_in,
  input wire logic [15:0] uv_limit_in,
  input wire logic pg_pin_enable_in,
  input wire logic clear_faults_in,
  input wire logic clear_fault_bit_in,
  input wire logic cmd_read_in,
  input wire logic read_valid_out,
  input wire logic output_enable_out,
  input wire logic ramp_active_out,
  input wire logic power_good_out,
  input wire logic power_good_status_out,
  input wire logic timeout_fault_out,
  input wire logic [2:0] attempt_count_out
);
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (reset_in);

  a_read_answer: assert property (cmd_read_in |=> read_valid_out)
    else $error("read answer missing");
  a_pg_status: assert property (power_good_out
    |-> !power_good_status_out)
    else $error("status disagrees with power good");
  a_pg_pin: assert property (!pg_pin_enable_in |=> !power_good_out)
    else $error("power good with pin disabled");
  a_pg_idle: assert property (ramp_active_out || !output_enable_out
    |-> !power_good_out)
    else $error("power good while off or ramping");
  a_ramp_on: assert property (ramp_active_out |-> output_enable_out)
    else $error("ramp without output");
  a_start_cause: assert property ($rose(output_enable_out)
    |-> $past(enable_pin_in, 3))
    else $error("start without enable");
  a_fault_cause: assert property ($rose(timeout_fault_out)
    |-> $past(vout_in < uv_limit_in))
    else $error("timeout with output above limit");
  a_off_cause: assert property ($fell(output_enable_out) && enable_pin_in
    && $past(enable_pin_in, 6) |-> ##[0:1] timeout_fault_out)
    else $error("output dropped without fault");
  a_fault_clear: assert property ($fell(timeout_fault_out)
    |-> $past(clear_faults_in) || $past(clear_fault_bit_in)
    || !output_enable_out)
    else $error("fault flag lost");
  a_attempt_step: assert property ($changed(attempt_count_out)
    |-> attempt_count_out == 3'h0
    || attempt_count_out == $past(attempt_count_out) + 3'h1)
    else $error("attempt count jumped");
endmodule
bind pwseq_top pwseq_asserts #(.MS_CYCLES_P(MS_CYCLES_P)) u_chk (
  .clock_in, .reset_in, .enable_pin_in, .vout_in, .uv_limit_in,
  .pg_pin_enable_in, .clear_faults_in, .clear_fault_bit_in, .cmd_read_in,
  .read_valid_out, .output_enable_out, .ramp_active_out, .power_good_out,
  .power_good_status_out, .timeout_fault_out, .attempt_count_out);
`default_nettype wire

// [pwseq_host.sv]
// management host model driving the command port
`timescale 1ns/1ps
`default_nettype none
module pwseq_host (
  input wire logic clock_in,
  input wire logic [15:0] read_data_in,
  input wire logic read_valid_in,
  output logic cmd_write_out,
  output logic cmd_read_out,
  output logic [7:0] cmd_code_out,
  output logic [15:0] cmd_data_out
);
  initial
  begin
    cmd_write_out = 1'b0;
    cmd_read_out = 1'b0;
    cmd_code_out = 8'h00;
    cmd_data_out = 16'h0000;
  end

  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    @(negedge clock_in);
    cmd_code_out = c;
    cmd_data_out = d;
    cmd_write_out = 1'b1;
    @(negedge clock_in);
    cmd_write_out = 1'b0;
    // idle lines toggle so stale values are never trusted
    cmd_code_out = ~c;
    cmd_data_out = ~d;
  endtask

  task automatic rd(input logic [7:0] c, output logic [15:0] d,
    output logic ok);
    @(negedge clock_in);
    cmd_code_out = c;
    cmd_read_out = 1'b1;
    @(negedge clock_in);
    ok = read_valid_in;
    d = read_data_in;
    cmd_read_out = 1'b0;
    cmd_code_out = ~c;
  endtask
endmodule
`default_nettype wire

// [test_pwseq_top.sv]
// self-checking testbench for the power-on sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) \
  begin \
    checks_done++; \
    if ((g) !== (e)) \
    begin \
      failures++; \
      $display("unexpected %0t: got %0h exp %0h", $time, g, e); \
    end \
  end
module test_pwseq_top;
  import pwseq_pkg::*;
  localparam int M = 10;
  logic clock_in, reset_in, enable_pin_in, pg_pin_enable_in;
  logic clear_faults_in, clear_fault_bit_in, cmd_write_in, cmd_read_in;
  logic [15:0] vout_in, uv_limit_in, cmd_data_in, read_data_out;
  logic [7:0] cmd_code_in;
  logic read_valid_out, output_enable_out, ramp_active_out;
  logic power_good_out, power_good_status_out, timeout_fault_out;
  logic [2:0] attempt_count_out;
  int failures = 0;
  int checks_done = 0;
  int n;

  pwseq_host host (.clock_in, .read_data_in(read_data_out),
    .read_valid_in(read_valid_out), .cmd_write_out(cmd_write_in),
    .cmd_read_out(cmd_read_in), .cmd_code_out(cmd_code_in),
    .cmd_data_out(cmd_data_in));
  pwseq_top #(.MS_CYCLES_P(M)) DUT (.clock_in, .reset_in, .enable_pin_in,
    .vout_in, .uv_limit_in, .pg_pin_enable_in, .clear_faults_in,
    .clear_fault_bit_in, .cmd_write_in, .cmd_read_in, .cmd_code_in,
    .cmd_data_in, .read_data_out, .read_valid_out, .output_enable_out,
    .ramp_active_out, .power_good_out, .power_good_status_out,
    .timeout_fault_out, .attempt_count_out);

  task automatic summarize();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge clock_in);
  endtask

  // sel 0 output, 1 fault flag, else ramp
  task automatic wait_for(input int sel, input logic v, output int c);
    logic s;
    c = 0;
    s = ~v;
    while (s !== v && c < 2000)
    begin
      @(negedge clock_in);
      c++;
      s = sel == 0 ? output_enable_out
        : sel == 1 ? timeout_fault_out : ramp_active_out;
    end
    if (s !== v)
    begin
      failures++;
      summarize();
    end
  endtask

  task automatic rng(input int c, input int lo, input int hi);
    `CHK(c >= lo && c <= hi, 1'b1);
  endtask

  task automatic pulse(input logic b);
    @(negedge clock_in);
    clear_faults_in = ~b;
    clear_fault_bit_in = b;
    @(negedge clock_in);
    clear_faults_in = 1'b0;
    clear_fault_bit_in = 1'b0;
  endtask

  task automatic cfg(input logic [15:0] lm, input logic [7:0] rp);
    host.wr(CMD_TON_LIMIT, lm);
    host.wr(CMD_TON_RESP, {8'h00, rp});
    enable_pin_in = 1'b1;
  endtask

  task automatic off();
    enable_pin_in = 1'b0;
    vout_in = 16'h0000;
    wait_for(0, 1'b0, n);
    cyc(4);
  endtask

  task automatic t_regs();
    logic [7:0] c [7] = '{CMD_PG_ASSERT, CMD_PG_NEGATE, CMD_ON_DELAY,
      CMD_ON_RISE, CMD_TON_LIMIT, CMD_TON_RESP, CMD_FAULT_UNIT};
    logic [15:0] d, w;
    logic ok;
    for (int i = 0; i < 7; i++)
    begin
      host.rd(c[i], d, ok);
      `CHK({ok, d}, {1'b1, i == 6 ? RST_FAULT_UNIT : RST_WORD});
      w = 16'h1A50 + 16'(i);
      host.wr(c[i], w);
      host.rd(c[i], d, ok);
      `CHK(d, i == 5 ? {8'h00, w[7:0]} : w);
    end
    host.wr(CMD_TON_RESP, 16'h0020);
    host.rd(CMD_TON_RESP, d, ok);
    `CHK(d, 16'h0055);
    host.wr(8'h10, 16'hFFFF);
    host.rd(8'h10, d, ok);
    `CHK(d, 16'h0000);
    host.wr(CMD_FAULT_UNIT, 16'h0001);
  endtask

  task automatic t_seq();
    host.wr(CMD_PG_ASSERT, 16'h0800);
    host.wr(CMD_PG_NEGATE, 16'h0600);
    host.wr(CMD_ON_DELAY, 16'h0003);
    host.wr(CMD_ON_RISE, 16'h0002);
    cfg(16'h0000, 8'h00);
    wait_for(0, 1'b1, n);
    rng(n, 2 * M, 3 * M + 8);
    `CHK(power_good_out, 1'b0);
    wait_for(2, 1'b0, n);
    rng(n, M, 2 * M + 4);
    cyc(5 * M);
    `CHK(timeout_fault_out, 1'b0);
    vout_in = 16'h0900;
    cyc(3);
    `CHK({power_good_out, power_good_status_out}, 2'b10);
    pg_pin_enable_in = 1'b0;
    cyc(3);
    `CHK(power_good_out, 1'b0);
    pg_pin_enable_in = 1'b1;
    vout_in = 16'h0650;
    cyc(3);
    `CHK(power_good_out, 1'b1);
    vout_in = 16'h0500;
    cyc(3);
    `CHK({power_good_out, power_good_status_out}, 2'b01);
    off();
    host.wr(CMD_ON_DELAY, 16'h0000);
    host.wr(CMD_ON_RISE, 16'h0000);
  endtask

  task automatic t_ignore();
    cfg(16'h0002, 8'h00);
    wait_for(1, 1'b1, n);
    rng(n, M, 3 * M + 8);
    cyc(5 * M);
    `CHK(output_enable_out, 1'b1);
    off();
    `CHK(timeout_fault_out, 1'b0);
  endtask

  task automatic t_retry();
    cfg(16'h0002, 8'h91);
    for (int k = 0; k < 3; k++)
    begin
      wait_for(0, 1'b1, n);
      if (k > 0)
        rng(n, M, 3 * M + 4);
      `CHK(attempt_count_out, 3'(k));
      wait_for(0, 1'b0, n);
      rng(n, M, 3 * M + 4);
    end
    cyc(8 * M);
    `CHK({output_enable_out, attempt_count_out}, 4'h2);
    vout_in = 16'h0900;
    pulse(1'b0);
    cyc(1);
    `CHK({timeout_fault_out, attempt_count_out}, 4'h0);
    wait_for(0, 1'b1, n);
    cyc(5 * M);
    `CHK({output_enable_out, timeout_fault_out}, 2'b10);
    off();
  endtask

  task automatic t_latch();
    cfg(16'h0002, 8'hC0);
    wait_for(0, 1'b1, n);
    wait_for(0, 1'b0, n);
    cyc(6 * M);
    `CHK(output_enable_out, 1'b0);
    pulse(1'b1);
    wait_for(0, 1'b1, n);
    rng(n, 1, 10);
    off();
  endtask

  task automatic t_delayed();
    host.wr(CMD_FAULT_UNIT, 16'h0002);
    cfg(16'h0002, 8'h41);
    wait_for(1, 1'b1, n);
    wait_for(0, 1'b0, n);
    rng(n, 3 * M, 5 * M + 4);
    cyc(8 * M);
    `CHK(output_enable_out, 1'b0);
    off();
    host.wr(CMD_FAULT_UNIT, 16'h0001);
  endtask

  task automatic t_forever();
    cfg(16'h0002, 8'hB8);
    for (int k = 0; k < 5; k++)
    begin
      wait_for(0, 1'b1, n);
      wait_for(0, 1'b0, n);
    end
    `CHK(timeout_fault_out, 1'b1);
    off();
  endtask

  initial
  begin
    clock_in = 1'b0;
    forever #50 clock_in = ~clock_in;
  end

  initial
  begin
    reset_in = 1'b1;
    enable_pin_in = 1'b0;
    vout_in = 16'h0000;
    uv_limit_in = 16'h0700;
    pg_pin_enable_in = 1'b1;
    clear_faults_in = 1'b0;
    clear_fault_bit_in = 1'b0;
    cyc(4);
    reset_in = 1'b0;
    t_regs();
    t_seq();
    t_ignore();
    t_retry();
    t_latch();
    t_delayed();
    t_forever();
    summarize();
  end
endmodule
`default_nettype wire
